// file: core/vbi_copy_pkg.sv
package vbi_copy_pkg;

  // Register indices; some printed offsets are not multiples of four, so address = 4 * index.
  localparam logic [7:0] idx_hd_ed_copy_control       = 8'h32;
  localparam logic [7:0] idx_hd_ed_copy_data_0        = 8'h41;
  localparam logic [7:0] idx_hd_ed_copy_data_1        = 8'h42;
  localparam logic [7:0] idx_hd_ed_copy_data_2        = 8'h43;
  localparam logic [7:0] idx_type_b_control_and_data  = 8'h5E;
  localparam logic [7:0] idx_type_b_last              = 8'h6E;
  localparam logic [7:0] idx_sd_vbi_control_and_data  = 8'h99;
  localparam logic [7:0] idx_sd_vbi_data_1            = 8'h9A;
  localparam logic [7:0] idx_sd_vbi_data_2            = 8'h9B;
  localparam logic [7:0] idx_sd_blanking_control      = 8'hA1;
  localparam logic [7:0] idx_video_mode               = 8'hF0;
  localparam logic [7:0] idx_status                   = 8'hF1;
  localparam int         type_b_regs                  = 17;

  // Field positions.
  localparam int bit_hd_copy_enable  = 6;
  localparam int bit_hd_crc_enable   = 7;
  localparam int bit_type_b_enable   = 0;
  localparam int bit_type_b_crc      = 1;
  localparam int bit_sd_crc_enable   = 4;
  localparam int bit_sd_field_lo     = 5;
  localparam int bit_sd_wss_enable   = 7;
  localparam int bit_sd_wss_blank    = 7;

  // Target line numbers.
  localparam logic [10:0] line_sd_odd       = 11'h014;
  localparam logic [10:0] line_sd_even      = 11'h11B;
  localparam logic [10:0] line_525p_copy    = 11'h029;
  localparam logic [10:0] line_525p_type_b  = 11'h028;
  localparam logic [10:0] line_625p_copy    = 11'h02B;
  localparam logic [10:0] line_720p_copy    = 11'h018;
  localparam logic [10:0] line_720p_type_b  = 11'h017;
  localparam logic [10:0] line_1080_copy_a  = 11'h013;
  localparam logic [10:0] line_1080_copy_b  = 11'h246;
  localparam logic [10:0] line_1080_tb_a    = 11'h012;
  localparam logic [10:0] line_1080_tb_b    = 11'h245;
  localparam logic [10:0] line_wss          = 11'h017;

  localparam logic [5:0]  crc_preset        = 6'h3F;
  localparam logic [31:0] reset_word        = 32'h0000_0000;

  // Pass-through point for active video on the signalling line.
  localparam real clk_mhz                   = 10.0;
  localparam real wss_video_start_us        = 42.5;
  localparam int  wss_video_start_cycles    = int'($ceil(wss_video_start_us * clk_mhz));

  typedef enum logic [2:0] {
    mode_ntsc, mode_pal, mode_525p, mode_625p, mode_720p, mode_1080i
  } video_mode_type;

  typedef enum logic [2:0] {
    kind_none, kind_sd_copy, kind_ed_copy, kind_625_copy, kind_type_b, kind_wss
  } packet_kind_type;

  typedef struct packed {
    logic            valid;
    packet_kind_type kind;
    logic [7:0]      bit_count;
    logic [133:0]    bits;
  } vbi_packet_type;

endpackage

// file: core/vbi_copy_control_inserter.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
// Overview of operation
// - Standard definition copy data goes on line 20 odd and line 283 even.
// - Two-bit field selects odd fields, even fields, or both for copy data.
// - Standard definition copy data is sent only in NTSC mode.
// - Copy word is 20 bits, preceded by a one-bit reference pulse.
// - In 525p with copy enable, three data registers go on line 41.
// - In 525p with Type B enable, seventeen registers go on line 40.
// - In 625p with copy enable, data registers 1 and 2 go on line 43.
// - In 720p with copy enable, copy data goes on line 24.
// - In 1080i with copy enable, copy data goes on lines 19 and 582.
// - In 720p with Type B enable, Type B data goes on line 23.
// - In 1080i with Type B enable, Type B data goes on lines 18 and 581.
// - With CRC enabled, top six copy bits are computed from lower 14 bits.
// - Every CRC uses polynomial x^6+x+1 preset to all ones.
// - With CRC disabled, all 20 register bits are sent unchanged.
// - With Type B CRC, six check bits follow 128 bits, 134 total.
// - With Type B CRC disabled, all 134 bits come from registers.
// - A 14-bit signalling word goes on line 23, only in PAL.
// - The signalling enable bit turns transmission of the word on or off.
// - Signalling data is preceded by a run-in sequence and start code.
// - Active video passes from 42.5 us after the sync falling edge.
// - A blanking bit blanks the signalling portion of line 23.
module vbi_copy_control_inserter
  import vbi_copy_pkg::*;
(
  // Clock and reset.
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // AXI4-Lite slave.
  input  wire logic [11:0]    s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [11:0]    s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  // Video timing, same clock.
  input  wire logic           line_start,
  input  wire logic [10:0]    line_number,
  input  wire logic           field_even,
  // Packet out to the waveform stage.
  output vbi_packet_type      packet,
  output logic                video_blank
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]     hd_ed_copy_control;
  logic [7:0]     hd_ed_copy_data [3];
  logic [7:0]     type_b_data [type_b_regs];
  logic [7:0]     sd_vbi_control_and_data;
  logic [7:0]     sd_vbi_data_1;
  logic [7:0]     sd_vbi_data_2;
  logic [7:0]     sd_blanking_control;
  video_mode_type video_mode;
  logic [7:0]     packet_count;
  logic           aw_held;
  logic           w_held;
  logic [9:0]     aw_index;
  logic [31:0]    w_data;
  logic [3:0]     w_strb;
  logic [15:0]    blank_count;

  function automatic logic [5:0] crc6(input logic [127:0] data, input int len);
    logic [5:0] r;
    logic       fb;
    r = crc_preset;
    for (int i = 0; i < 128; i++) begin
      if (i < len) begin
        fb = r[5] ^ data[i];
        r  = {r[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
      end
    end
    return r;
  endfunction

  function automatic logic [19:0] copy_word(input logic [19:0] raw, input logic crc_on);
    logic [19:0] w;
    w = raw;
    if (crc_on) begin
      w[19:14] = crc6({114'h0, raw[13:0]}, 14);
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data are taken independently.
  logic write_go;
  assign write_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_index      <= 10'h000;
      w_data        <= reset_word;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready  <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held  <= 1'b1;
        aw_index <= s_axi_awaddr[11:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (write_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_known(aw_index) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic reg_known(input logic [9:0] idx);
    return idx == 10'(idx_hd_ed_copy_control) ||
           (idx >= 10'(idx_hd_ed_copy_data_0) && idx <= 10'(idx_hd_ed_copy_data_2)) ||
           (idx >= 10'(idx_type_b_control_and_data) && idx <= 10'(idx_type_b_last)) ||
           (idx >= 10'(idx_sd_vbi_control_and_data) && idx <= 10'(idx_sd_vbi_data_2)) ||
           idx == 10'(idx_sd_blanking_control) || idx == 10'(idx_video_mode) ||
           idx == 10'(idx_status);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage; only byte lane 0 carries data.
  logic do_wr;
  assign do_wr = write_go && w_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hd_ed_copy_control      <= 8'h00;
      sd_vbi_control_and_data <= 8'h00;
      sd_vbi_data_1           <= 8'h00;
      sd_vbi_data_2           <= 8'h00;
      sd_blanking_control     <= 8'h00;
      video_mode              <= mode_ntsc;
      for (int i = 0; i < 3; i++) begin
        hd_ed_copy_data[i] <= 8'h00;
      end
      for (int i = 0; i < type_b_regs; i++) begin
        type_b_data[i] <= 8'h00;
      end
    end else if (do_wr) begin
      if (aw_index == 10'(idx_hd_ed_copy_control)) hd_ed_copy_control <= w_data[7:0];
      if (aw_index == 10'(idx_sd_vbi_control_and_data)) sd_vbi_control_and_data <= w_data[7:0];
      if (aw_index == 10'(idx_sd_vbi_data_1)) sd_vbi_data_1 <= w_data[7:0];
      if (aw_index == 10'(idx_sd_vbi_data_2)) sd_vbi_data_2 <= w_data[7:0];
      if (aw_index == 10'(idx_sd_blanking_control)) sd_blanking_control <= w_data[7:0];
      if (aw_index == 10'(idx_video_mode) && w_data[2:0] <= 3'h5) video_mode <= video_mode_type'(w_data[2:0]);
      for (int i = 0; i < 3; i++) begin
        if (aw_index == 10'(idx_hd_ed_copy_data_0) + 10'(i)) hd_ed_copy_data[i] <= w_data[7:0];
      end
      for (int i = 0; i < type_b_regs; i++) begin
        if (aw_index == 10'(idx_type_b_control_and_data) + 10'(i)) type_b_data[i] <= w_data[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read.
  function automatic logic [7:0] read_reg(input logic [9:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == 10'(idx_hd_ed_copy_control)) v = hd_ed_copy_control;
    if (idx == 10'(idx_sd_vbi_control_and_data)) v = sd_vbi_control_and_data;
    if (idx == 10'(idx_sd_vbi_data_1)) v = sd_vbi_data_1;
    if (idx == 10'(idx_sd_vbi_data_2)) v = sd_vbi_data_2;
    if (idx == 10'(idx_sd_blanking_control)) v = sd_blanking_control;
    if (idx == 10'(idx_video_mode)) v = {5'h00, video_mode};
    if (idx == 10'(idx_status)) v = packet_count;
    for (int i = 0; i < 3; i++) begin
      if (idx == 10'(idx_hd_ed_copy_data_0) + 10'(i)) v = hd_ed_copy_data[i];
    end
    for (int i = 0; i < type_b_regs; i++) begin
      if (idx == 10'(idx_type_b_control_and_data) + 10'(i)) v = type_b_data[i];
    end
    return v;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= reset_word;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, read_reg(s_axi_araddr[11:2])};
        s_axi_rresp   <= reg_known(s_axi_araddr[11:2]) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line selection and packet assembly at each line start.
  logic [19:0]  sd_raw;
  logic [19:0]  ed_raw;
  logic [127:0] tb_low;
  logic         sd_line;
  logic         ed_line;
  logic         tb_line;
  logic         wss_line;

  assign sd_raw = {sd_vbi_data_2, sd_vbi_data_1, sd_vbi_control_and_data[3:0]};
  assign ed_raw = {hd_ed_copy_data[2][3:0], hd_ed_copy_data[1], hd_ed_copy_data[0]};

  always_comb begin
    tb_low = '0;
    for (int i = 1; i < type_b_regs; i++) begin
      tb_low[(i-1)*8 +: 8] = type_b_data[i];
    end
  end

  assign sd_line = video_mode == mode_ntsc && (
                   (line_number == line_sd_odd && !field_even && sd_vbi_control_and_data[bit_sd_field_lo]) ||
                   (line_number == line_sd_even && field_even && sd_vbi_control_and_data[bit_sd_field_lo+1]));

  assign ed_line = hd_ed_copy_control[bit_hd_copy_enable] && (
                   (video_mode == mode_525p && line_number == line_525p_copy) ||
                   (video_mode == mode_625p && line_number == line_625p_copy) ||
                   (video_mode == mode_720p && line_number == line_720p_copy) ||
                   (video_mode == mode_1080i && (line_number == line_1080_copy_a ||
                                                 line_number == line_1080_copy_b)));

  assign tb_line = type_b_data[0][bit_type_b_enable] && (
                   (video_mode == mode_525p && line_number == line_525p_type_b) ||
                   (video_mode == mode_720p && line_number == line_720p_type_b) ||
                   (video_mode == mode_1080i && (line_number == line_1080_tb_a ||
                                                 line_number == line_1080_tb_b)));

  assign wss_line = video_mode == mode_pal && line_number == line_wss &&
                    sd_vbi_control_and_data[bit_sd_wss_enable];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      packet       <= '0;
      packet_count <= 8'h00;
    end else if (line_start) begin
      packet.valid <= sd_line || ed_line || tb_line || wss_line;
      if (sd_line || ed_line || tb_line || wss_line) packet_count <= packet_count + 8'h01;
      if (sd_line) begin
        packet.kind      <= kind_sd_copy;
        packet.bit_count <= 8'h15;
        packet.bits      <= {113'h0, copy_word(sd_raw, sd_vbi_control_and_data[bit_sd_crc_enable]), 1'b1};
      end else if (ed_line && video_mode == mode_625p) begin
        packet.kind      <= kind_625_copy;
        packet.bit_count <= 8'h0E;
        packet.bits      <= {120'h0, hd_ed_copy_data[2][5:0], hd_ed_copy_data[1]};
      end else if (ed_line) begin
        packet.kind      <= kind_ed_copy;
        packet.bit_count <= 8'h14;
        packet.bits      <= {114'h0, copy_word(ed_raw, hd_ed_copy_control[bit_hd_crc_enable])};
      end else if (tb_line) begin
        packet.kind      <= kind_type_b;
        packet.bit_count <= 8'h86;
        packet.bits      <= {type_b_data[0][bit_type_b_crc] ? crc6(tb_low, 128)
                             : type_b_data[0][7:2], tb_low};
      end else if (wss_line) begin
        packet.kind      <= kind_wss;
        packet.bit_count <= 8'h0E;
        // The waveform stage prefixes the run-in and start code for this kind.
        packet.bits      <= {120'h0, sd_vbi_data_2[5:0], sd_vbi_data_1};
      end else begin
        packet.kind      <= kind_none;
        packet.bit_count <= 8'h00;
        packet.bits      <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blanking of the signalling portion; video passes after the start point.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_count <= 16'h0000;
      video_blank <= 1'b0;
    end else if (line_start) begin
      blank_count <= 16'h0000;
      video_blank <= video_mode == mode_pal && line_number == line_wss &&
                     sd_blanking_control[bit_sd_wss_blank];
    end else begin
      if (blank_count != 16'hFFFF) blank_count <= blank_count + 16'h0001;
      if (blank_count == 16'(wss_video_start_cycles - 1)) video_blank <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  blank_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!line_start && blank_count == 16'(wss_video_start_cycles - 1)) |=> !video_blank)
    else $error("video blank held past start point");
  sd_mode_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (packet.valid && packet.kind == kind_sd_copy) |-> video_mode == mode_ntsc)
    else $error("sd copy packet outside ntsc");
  sd_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (packet.kind == kind_sd_copy) |-> packet.bit_count == 8'h15 && packet.bits[0])
    else $error("sd copy length or reference wrong");
  tb_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (packet.kind == kind_type_b) |-> packet.bit_count == 8'h86)
    else $error("type b length wrong");
  tb_crc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (line_start && tb_line && !sd_line && !ed_line && type_b_data[0][bit_type_b_crc])
      |=> packet.bits[133:128] == crc6(packet.bits[127:0], 128))
    else $error("type b check bits wrong");
  ed_crc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (line_start && ed_line && !sd_line && video_mode != mode_625p && hd_ed_copy_control[bit_hd_crc_enable])
      |=> packet.bits[19:14] == crc6({114'h0, packet.bits[13:0]}, 14))
    else $error("copy word check bits wrong");
  ed_raw_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (line_start && ed_line && !sd_line && video_mode != mode_625p && !hd_ed_copy_control[bit_hd_crc_enable])
      |=> packet.bits[19:0] == $past(ed_raw))
    else $error("raw copy word altered");
  wss_pal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (packet.valid && packet.kind == kind_wss) |-> video_mode == mode_pal && packet.bit_count == 8'h0E)
    else $error("signalling word outside pal");
  wss_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (line_start && !sd_vbi_control_and_data[bit_sd_wss_enable]) |=> packet.kind != kind_wss)
    else $error("signalling word sent while disabled");
  line_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !line_start |=> $stable(packet))
    else $error("packet changed mid line");

  sd_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) packet.valid && packet.kind == kind_sd_copy);
  tb_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) packet.valid && packet.kind == kind_type_b);
  wss_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) packet.valid && packet.kind == kind_wss);
  blank_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) $fell(video_blank));

endmodule

// file: verification/vbi_receiver_model.sv
`timescale 1ns/1ns
// Receiving set: counts the packets that reach it and checks the sd reference pulse.
module vbi_receiver_model
  import vbi_copy_pkg::*;
(
  // Clock and reset.
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // Line data from the encoder.
  input  wire logic           line_start,
  input  wire vbi_packet_type packet,
  // Decoder results.
  output int                  got,
  output int                  bad_ref
);
  logic seen;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen    <= 1'b0;
      got     <= 0;
      bad_ref <= 0;
    end else begin
      seen <= line_start;
      if (seen && packet.valid) begin
        got <= got + 1;
        if (packet.kind == kind_sd_copy && packet.bits[0] !== 1'b1) begin
          bad_ref <= bad_ref + 1;
        end
      end
    end
  end
endmodule

// file: verification/tb_vbi_copy_control_inserter.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_vbi_copy_control_inserter
  import vbi_copy_pkg::*;
;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, line_start = 0, field_even = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, video_blank;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h00012A04;
  logic [3:0] s_axi_wstrb = 0;
  logic [10:0] line_number = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] rg [256];
  logic [133:0] hold;
  vbi_packet_type packet;
  int errors = 0, checks = 0, cycles = 0, mode = 0, sent = 0, got, bad_ref;
  int lines [11] = '{20, 283, 18, 19, 23, 24, 40, 41, 43, 581, 582};

  vbi_copy_control_inserter dut_u (.*);
  vbi_receiver_model rx_u (.aclk(aclk), .aresetn(aresetn), .line_start(line_start), .packet(packet),
                           .got(got), .bad_ref(bad_ref));

  always #50 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [5:0] crc6(input logic [133:0] d, input int n);
    logic [5:0] c;
    c = 6'h3F;
    for (int i = 0; i < n; i++) c = {c[4:0], 1'b0} ^ (d[i] ^ c[5] ? 6'h03 : 6'h00);
    return c;
  endfunction

  task automatic summarize();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Bus cycles: offered together, each channel released once taken, response awaited.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n = 0;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
    if (er == 2'h0) rg[idx] = d;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    int n = 0;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rresp, er)
    `CHK(s_axi_rdata, {24'h0, e})
    @(posedge aclk);
  endtask

  // Reference model of the packet that a line should carry.
  task automatic model(input logic [10:0] n, input logic ev, output logic v, output packet_kind_type k,
                       output logic [133:0] b, output logic [133:0] m);
    logic [7:0] c, t, h;
    int w;
    c = rg['h99];
    t = rg['h5E];
    h = rg['h32];
    v = 1'b1;
    k = kind_none;
    b = '0;
    w = 14;
    if (mode == 0 && (n == line_sd_odd && !ev && c[5] || n == line_sd_even && ev && c[6])) begin
      k = kind_sd_copy;
      w = 21;
      b[20:0] = {rg['h9B], rg['h9A], c[3:0], 1'b1};
      if (c[4]) b[20:15] = crc6(b >> 1, 14);
    end else if (h[6] && (mode == 2 && n == line_525p_copy || mode == 4 && n == line_720p_copy ||
                 mode == 5 && (n == line_1080_copy_a || n == line_1080_copy_b))) begin
      k = kind_ed_copy;
      w = 20;
      b[19:0] = {rg['h43][3:0], rg['h42], rg['h41]};
      if (h[7]) b[19:14] = crc6(b, 14);
    end else if (h[6] && mode == 3 && n == line_625p_copy) begin
      k = kind_625_copy;
      b[13:0] = {rg['h43][5:0], rg['h42]};
    end else if (t[0] && (mode == 2 && n == line_525p_type_b || mode == 4 && n == line_720p_type_b ||
                 mode == 5 && (n == line_1080_tb_a || n == line_1080_tb_b))) begin
      k = kind_type_b;
      w = 134;
      for (int i = 1; i <= 16; i++) b[8*(i-1) +: 8] = rg['h5E + i];
      b[133:128] = t[1] ? crc6(b, 128) : t[7:2];
    end else if (mode == 1 && n == line_wss && c[7]) begin
      k = kind_wss;
      b[13:0] = {rg['h9B][5:0], rg['h9A]};
    end else v = 1'b0;
    m = ~({134{1'b1}} << w);
  endtask

  task automatic ln(input logic [10:0] n, input logic ev);
    logic v, bl;
    packet_kind_type k;
    logic [133:0] b, m;
    model(n, ev, v, k, b, m);
    bl = mode == 1 && n == line_wss && rg['hA1][7];
    line_start <= 1'b1;
    line_number <= n;
    field_even <= ev;
    @(posedge aclk);
    line_start <= 1'b0;
    @(negedge aclk);
    `CHK(packet.valid, v)
    if (v) begin `CHK(packet.kind, k) `CHK(packet.bits & m, b) end
    if (v) `CHK(packet.bit_count, 8'($countones(m)))
    `CHK(video_blank, bl)
    if (bl) begin
      repeat (wss_video_start_cycles - 1) @(negedge aclk);
      `CHK(video_blank, 1'b1)
      @(negedge aclk);
      `CHK(video_blank, 1'b0)
    end
    sent += v;
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin errors++; summarize(); end
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h10, 8'h00, 2'h2);
    wr(8'h10, 8'h5A, 2'h2);
    wr(8'h41, 8'hA5, 2'h0);
    rd(8'h41, 8'hA5, 2'h0);
    wr(8'hF0, 8'h07, 2'h0);
    rd(8'hF0, 8'h00, 2'h0);
    $display("test registers done");
    for (int r = 0; r < 8; r++) begin
      foreach (rg[j]) if (j inside {'h32, ['h41:'h43], ['h5E:'h6E], ['h99:'h9B], 'hA1}) wr(j, rnd(), 2'h0);
      wr(8'h9A, rg['h9A] & 8'h7F, 2'h0);
      for (int md = 0; md < 6; md++) begin
        wr(8'hF0, 8'(md), 2'h0);
        mode = md;
        for (int e = 0; e < 2; e++) foreach (lines[j]) ln(11'(lines[j]), e[0]);
      end
    end
    $display("test insertion done");
    wr(8'hF0, 8'h00, 2'h0);
    mode = 0;
    wr(8'h99, 8'h20, 2'h0);
    ln(11'd20, 1'b0);
    hold = packet.bits;
    wr(8'h9A, ~rg['h9A], 2'h0);
    `CHK(packet.bits, hold)
    ln(11'd20, 1'b0);
    $display("test update timing done");
    rd(8'hF1, 8'(sent), 2'h0);
    `CHK(got, sent)
    `CHK(bad_ref, 0)
    summarize();
  end
endmodule
